//--- design/lps_cfg.svh
// offsets, field positions, reset values and counts of the low power ctrl
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH
`define LPS_ADR_CTRL     4'h0
`define LPS_ADR_STATE    4'h4
`define LPS_ADR_STRAP    4'h8
`define LPS_ADR_EVT      4'hC
`define LPS_CTRL_RESUME  0
`define LPS_CTRL_HALT    1
`define LPS_SG_DELAY     20
`define LPS_SYW          33
`define LPS_SY_ADDR      0
`define LPS_SY_BR0       25
`define LPS_SY_LINT      26
`define LPS_SY_BUS_INIT_REQ     28
`define LPS_SY_INIT      29
`define LPS_SY_SMI       30
`define LPS_SY_SLP       31
`define LPS_SY_STP       32
`define LPS_SY_RST       33'h1F3FFFFFF
`define LPS_EVW          6
`define LPS_EV_SMI       0
`define LPS_EV_INIT      1
`define LPS_EV_BUS_INIT_REQ     2
`define LPS_EV_LINT      3
`define LPS_EV_FSB       5
`define LPS_STRAPW       10
`define LPS_BOOT_DONE    2'h2
`endif

//--- design/lps_pkg.sv
// types of the low power state controller
package lps_pkg;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_HALT   = 3'h1,
    ST_ACK    = 3'h2,
    ST_COUNT  = 3'h3,
    ST_SG     = 3'h4,
    ST_SNOOP  = 3'h5,
    ST_SLEEP  = 3'h6
  } lps_state_t;
endpackage

//--- design/lps_ctrl.sv
// strap capture and stop-clock low power state controller
// Functional notes
// RL1: straps caught when reset is released
// RL2: straps fixed until next reset, every reset
// RL3: asserted strap pin selects its option
// RL4: A7 strap limits transaction queue to one
// RL5: cluster id from address lines 12, 11
// RL6: A9 A10 A15 A31 BR0 strap effects
// RL7: far side keeps reserved address lines idle
// RL8: halt instruction enters auto halt powerdown
// RL9: interrupt events wake halt to normal
// RL10: reset in halt initialises at once
// RL11: handler return resumes normal or halt
// RL12: clock stop from halt returns to halt
// RL13: halt still serves snoops and interrupts
// RL14: acknowledge cycle, stop grant 20 clocks later
// RL15: far side idles bus pins in stop grant
// RL16: stop grant latches events, once each
// RL17: reset in stop grant stays stop grant
// RL18: clock stop release returns to normal
// RL19: far side orders sleep, stop releases
// RL20: snoop enters snoop state, sleep enters sleep
// RL21: stop grant serves snoops, latches bus irqs
// RL22: pending break shows any latched interrupt
// RL23: snoop state returns to its origin
// RL24: sleep only from stop grant
// RL25: exactly one of five states reported
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "lps_cfg.svh"
module lps_ctrl
  import lps_pkg::*;
#(
  parameter int SG_DELAY = `LPS_SG_DELAY
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        clock_stop_req_n_i,
  input  wire logic        sleep_req_n_i,
  input  wire logic        system_mgmt_irq_n_i,
  input  wire logic        soft_init_n_i,
  input  wire logic        bus_init_req_n_i,
  input  wire logic [1:0]  local_irq_lines_i,
  input  wire logic        bus_req_line_zero_n_i,
  input  wire logic [31:7] strap_addr_n_i,
  input  wire logic        halt_exec_i,
  input  wire logic        smi_return_i,
  input  wire logic        snoop_i,
  input  wire logic        snoop_done_i,
  input  wire logic        fsb_irq_i,
  input  wire logic        sg_ack_resp_i,
  output logic             sg_ack_req_o,
  output logic             pending_break_event_n_o,
  output logic [4:0]       state_o,
  output logic [9:0]       strap_o
);

  // count from the response edge so stop grant lands SG_DELAY clocks on
  localparam logic [4:0] SG_LOAD = 5'(SG_DELAY - 1);

  // pin synchroniser, one pair of flops per bit
  logic [`LPS_SYW-1:0] pins;
  logic [`LPS_SYW-1:0] sy;
  localparam logic [`LPS_SYW-1:0] SY_RST = `LPS_SY_RST;

  assign pins = {clock_stop_req_n_i, sleep_req_n_i, system_mgmt_irq_n_i,
                 soft_init_n_i, bus_init_req_n_i, local_irq_lines_i,
                 bus_req_line_zero_n_i, strap_addr_n_i};

  genvar g;
  generate
    for (g = 0; g < `LPS_SYW; g++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_reg <= SY_RST[g];
          s2_reg <= SY_RST[g];
        end else begin
          s1_reg <= pins[g];
          s2_reg <= s1_reg;
        end
      end
      assign sy[g] = s2_reg;
    end
  endgenerate

  wire       stp  = ~sy[`LPS_SY_STP];
  wire       slp  = ~sy[`LPS_SY_SLP];
  wire       smi  = ~sy[`LPS_SY_SMI];
  wire       init = ~sy[`LPS_SY_INIT];
  wire       bini = ~sy[`LPS_SY_BUS_INIT_REQ];
  wire [1:0] lint = sy[`LPS_SY_LINT +: 2];
  wire       wake = smi | init | bini | (|lint);

  // straps are taken once the synchroniser holds the released level
  logic [1:0] boot_reg;
  logic [1:0] boot_next;
  wire        boot_cap = (boot_reg == `LPS_BOOT_DONE);
  wire        booted   = (boot_reg == 2'h3);
  assign boot_next = booted ? boot_reg : boot_reg + 2'h1;

  wire [24:0] an = ~sy[`LPS_SY_ADDR +: 25];
  logic [9:0] strap_reg;
  logic [9:0] strap_next;
  assign strap_next = {
    ~sy[`LPS_SY_BR0],          // arbitration id
    an[31-7],                  // multithreading off
    an[15-7],                  // bus parking off
    an[12-7], an[11-7],        // cluster id
    an[10-7],                  // bus init observation off
    an[9-7],                   // machine check observation off
    an[7-7],                   // queue depth one
    init,                      // self test
    smi                        // output tristate
  };

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_reg  <= 2'h0;
      strap_reg <= 10'h000;
    end else begin
      boot_reg <= boot_next;
      if (boot_cap) begin
        strap_reg <= strap_next; // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6]
      end
    end
  end

  // wishbone register decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = (wb_adr_i == `LPS_ADR_CTRL);
  wire hit_st   = (wb_adr_i == `LPS_ADR_STATE);
  wire hit_sp   = (wb_adr_i == `LPS_ADR_STRAP);
  wire hit_evt  = (wb_adr_i == `LPS_ADR_EVT);

  logic        resume_reg;
  logic        halt_cmd_reg;
  logic [5:0]  evt_reg;
  logic [5:0]  evt_next;
  logic [5:0]  evt_set;
  logic [5:0]  evt_clr;
  lps_state_t  st_reg;
  lps_state_t  st_next;
  lps_state_t  origin_reg;
  lps_state_t  origin_next;
  logic        snp_sg_reg;
  logic        snp_sg_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  vis;
  logic [31:0] rd_data;

  wire halt_go = halt_exec_i | halt_cmd_reg;
  wire in_sg   = (st_reg == ST_SG) | (st_reg == ST_SNOOP & snp_sg_reg);

  // events wait in stop grant; set beats a same-cycle clear
  assign evt_set = in_sg ? {fsb_irq_i, lint, bini, init, smi}
                         : 6'h00; // [RL16] [RL21]
  assign evt_clr = (wb_wr & hit_evt) ? wb_dat_i[5:0] : 6'h00;
  assign evt_next = (evt_reg & ~evt_clr) | evt_set;

  assign rd_data = hit_ctrl ? {30'h0, halt_cmd_reg, resume_reg} :
                   hit_st   ? {27'h0, state_o} :
                   hit_sp   ? {22'h0, strap_reg} :
                   hit_evt  ? {26'h0, evt_reg} : 32'h0000_0000;

  // state sequencing
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_NORMAL: begin
        if (!booted) begin
          // clock stop still held across reset: stay stopped
          if (boot_cap && stp) begin
            st_next = ST_SG; // [RL17]
          end
        end else if (stp) begin
          st_next = ST_ACK; // [RL14]
        end else if (halt_go) begin
          st_next = ST_HALT; // [RL8]
        end else if (smi_return_i && resume_reg) begin
          st_next = ST_HALT; // [RL11]
        end
      end
      ST_HALT: begin
        if (wake) begin
          st_next = ST_NORMAL; // [RL9]
        end else if (stp) begin
          st_next = ST_ACK; // [RL12]
        end else if (snoop_i || fsb_irq_i) begin
          st_next = ST_SNOOP; // [RL13]
        end
      end
      ST_ACK: begin
        if (sg_ack_resp_i) begin
          st_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (cnt_reg == 5'h00) begin
          st_next = ST_SG; // [RL14]
        end
      end
      ST_SG: begin
        if (!stp) begin
          st_next = origin_reg; // [RL18] [RL12]
        end else if (snoop_i) begin
          st_next = ST_SNOOP; // [RL20] [RL21]
        end else if (slp) begin
          st_next = ST_SLEEP; // [RL20] [RL24]
        end
      end
      ST_SNOOP: begin
        if (snoop_done_i || (!snp_sg_reg && !snoop_i)) begin
          st_next = snp_sg_reg ? ST_SG : ST_HALT; // [RL23]
        end
      end
      ST_SLEEP: begin
        if (!slp) begin
          st_next = ST_SG; // [RL19] [RL24]
        end
      end
      default: st_next = ST_NORMAL;
    endcase
  end

  // acknowledge and count report the state they started from
  always_comb begin
    vis = 5'h01;
    unique case (st_next)
      ST_NORMAL: vis = 5'h01;
      ST_HALT:   vis = 5'h02;
      ST_ACK:    vis = (origin_next == ST_HALT) ? 5'h02 : 5'h01;
      ST_COUNT:  vis = (origin_next == ST_HALT) ? 5'h02 : 5'h01;
      ST_SG:     vis = 5'h04;
      ST_SNOOP:  vis = 5'h08;
      ST_SLEEP:  vis = 5'h10;
      default:   vis = 5'h01;
    endcase
  end

  // stop origin kept apart from snoop origin so a snoop in stop grant
  // cannot lose the halt that the stop episode must return to
  assign origin_next = (st_next == ST_ACK && st_reg != ST_ACK) ?
                       st_reg : origin_reg;
  assign snp_sg_next = (st_next == ST_SNOOP && st_reg != ST_SNOOP) ?
                       (st_reg == ST_SG) : snp_sg_reg;

  wire [4:0] cnt_next = (st_next == ST_COUNT && st_reg == ST_ACK) ?
                        SG_LOAD : cnt_reg - 5'h01;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg     <= ST_NORMAL; // [RL10]
      origin_reg <= ST_NORMAL;
      snp_sg_reg <= 1'b0;
      cnt_reg    <= 5'h00;
      state_o    <= 5'h01;
    end else begin
      st_reg     <= st_next;
      origin_reg <= origin_next;
      snp_sg_reg <= snp_sg_next;
      cnt_reg    <= cnt_next;
      state_o    <= vis; // [RL25]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resume_reg   <= 1'b0;
      halt_cmd_reg <= 1'b0;
      evt_reg      <= 6'h00;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end else begin
      evt_reg  <= evt_next;
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
      // halt command is a one-shot
      halt_cmd_reg <= wb_wr & hit_ctrl & wb_dat_i[`LPS_CTRL_HALT];
      if (wb_wr && hit_ctrl) begin
        resume_reg <= wb_dat_i[`LPS_CTRL_RESUME];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sg_ack_req_o            <= 1'b0;
      pending_break_event_n_o <= 1'b1;
      strap_o                 <= 10'h000;
    end else begin
      sg_ack_req_o <= (st_next == ST_ACK); // [RL14]
      // interrupt enable flag deliberately not consulted
      pending_break_event_n_o <= ~((st_next == ST_SG) & (|evt_next)); // [RL22]
      strap_o <= strap_reg;
    end
  end

  strap_hold_a: assert property ( // [RL2]
    @(posedge clk_i) disable iff (rst_i)
    booted |=> $stable(strap_reg))
    else $error("strap settings changed after capture");

  strap_take_a: assert property ( // [RL1]
    @(posedge clk_i) disable iff (rst_i)
    boot_cap |=> strap_reg == $past(strap_next))
    else $error("straps not captured at release");

  sg_delay_a: assert property ( // [RL14]
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == ST_ACK && sg_ack_resp_i) |-> ##21 st_reg == ST_SG)
    else $error("stop grant not entered 20 clocks after response");

  halt_wake_a: assert property ( // [RL9]
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == ST_HALT && wake) |=> state_o == 5'h01)
    else $error("halt did not wake to normal");

  halt_entry_a: assert property ( // [RL8]
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == ST_NORMAL && booted && !stp && halt_exec_i)
      |=> state_o == 5'h02)
    else $error("halt instruction did not enter halt");

  stop_back_a: assert property ( // [RL12]
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == ST_SG && !stp && origin_reg == ST_HALT)
      |=> st_reg == ST_HALT)
    else $error("stop release did not return to halt");

  sleep_entry_a: assert property ( // [RL20]
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == ST_SG && stp && !snoop_i && slp) |=> st_reg == ST_SLEEP)
    else $error("sleep request not honoured");

  sleep_only_a: assert property ( // [RL24]
    @(posedge clk_i) disable iff (rst_i)
    (st_next == ST_SLEEP && st_reg != ST_SLEEP) |-> st_reg == ST_SG)
    else $error("sleep entered from outside stop grant");

  break_out_a: assert property ( // [RL22]
    @(posedge clk_i) disable iff (rst_i)
    (st_reg == ST_SG && st_next == ST_SG && |evt_next)
      |=> !pending_break_event_n_o)
    else $error("pending break not shown");

  one_state_a: assert property ( // [RL25]
    @(posedge clk_i) disable iff (rst_i)
    $onehot(state_o))
    else $error("reported state not exactly one");

  wb_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

//--- bench/lps_chipset_model.sv
// chipset model: stop and sleep requests, acknowledge response
`timescale 1ns/1ps
module lps_chipset_model (
  input  wire logic       clk_i,
  input  wire logic       stop_cmd_i,
  input  wire logic       sleep_cmd_i,
  input  wire logic [3:0] resp_dly_i,
  input  wire logic       sg_ack_req_i,
  output logic            clock_stop_req_n_o = 1'b1,
  output logic            sleep_req_n_o = 1'b1,
  output logic            sg_ack_resp_o = 1'b0
);
  logic [3:0] wait_reg = 4'h0;
  // sleep only on a held stop; stop lets go a clock after sleep does
  always @(posedge clk_i) begin
    sleep_req_n_o <= ~(sleep_cmd_i & ~clock_stop_req_n_o);
    if (stop_cmd_i)
      clock_stop_req_n_o <= 1'b0;
    else if (sleep_req_n_o)
      clock_stop_req_n_o <= 1'b1;
    sg_ack_resp_o <= 1'b0;
    if (sg_ack_req_i && !sg_ack_resp_o) begin
      wait_reg <= wait_reg + 4'h1;
      if (wait_reg == resp_dly_i) begin
        sg_ack_resp_o <= 1'b1;
        wait_reg      <= 4'h0;
      end
    end
  end
endmodule

//--- bench/low_power_state_ctrl_tb.sv
// self-checking bench of the low power state controller
`timescale 1ns/1ps
module low_power_state_ctrl_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic [31:0] rdat, q;
  logic        ack, stp_n, slp_n, sgreq, sgresp, pbe_n;
  logic        stop_cmd = 1'b0;
  logic        sleep_cmd = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        smi_n = 1'b0;
  logic        init_n = 1'b1;
  logic        bus_init_req_n = 1'b1;
  logic [1:0]  lint = 2'h0;
  logic        br0_n = 1'b1;
  logic [31:7] addr_n = 25'h0FFFFDE;
  logic        halt = 1'b0;
  logic        smiret = 1'b0;
  logic        snoop = 1'b0;
  logic        sdone = 1'b0;
  logic        fsbirq = 1'b0;
  logic [4:0]  state;
  logic [9:0]  strap;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc_cnt = 0;
  int          n;

  lps_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
    .clock_stop_req_n_i(stp_n), .sleep_req_n_i(slp_n),
    .system_mgmt_irq_n_i(smi_n), .soft_init_n_i(init_n),
    .bus_init_req_n_i(bus_init_req_n), .local_irq_lines_i(lint),
    .bus_req_line_zero_n_i(br0_n), .strap_addr_n_i(addr_n),
    .halt_exec_i(halt), .smi_return_i(smiret), .snoop_i(snoop),
    .snoop_done_i(sdone), .fsb_irq_i(fsbirq), .sg_ack_resp_i(sgresp),
    .sg_ack_req_o(sgreq), .pending_break_event_n_o(pbe_n),
    .state_o(state), .strap_o(strap));

  lps_chipset_model chipset (.clk_i(clk_i), .stop_cmd_i(stop_cmd),
    .sleep_cmd_i(sleep_cmd), .resp_dly_i(dly), .sg_ack_req_i(sgreq),
    .clock_stop_req_n_o(stp_n), .sleep_req_n_o(slp_n),
    .sg_ack_resp_o(sgresp));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // read data and ack are taken at the edge that sees ack high
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] d);
    adr  <= a;
    we   <= w;
    wdat <= d;
    cyc  <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wst(input logic [4:0] e);
    n = 0;
    while (state !== e && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk(state, e);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pulse_halt();
    halt <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
    wst(5'h02);
  endtask

  initial begin
    do_reset();
    chk(strap, 10'h145);
    chk({sgreq, pbe_n, state}, 7'h21);
    smi_n  <= 1'b1;
    addr_n <= 25'h1FFFFFF;
    repeat (5) @(posedge clk_i);
    chk(strap, 10'h145);
    wb(4'h8, 1'b0, 32'h0);
    chk(q, 32'h145);
    wb(4'h2, 1'b1, 32'hFFFFFFFF);
    wb(4'h2, 1'b0, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 5; i++) begin
      pulse_halt();
      {lint, bus_init_req_n, init_n, smi_n} <= {2'(5'h01 << i >> 3),
                                         ~3'(5'h01 << i)};
      wst(5'h01);
      {lint, bus_init_req_n, init_n, smi_n} <= 5'h07;
      repeat (4) @(posedge clk_i);
    end
    pulse_halt();
    stop_cmd <= 1'b1;
    n = 0;
    while (sgresp !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk(sgreq, 1'b1);
    repeat (20) @(posedge clk_i);
    chk(state, 5'h02);
    @(posedge clk_i);
    chk(state, 5'h04);
    stop_cmd <= 1'b0;
    wst(5'h02);
    // a slow chipset answer must not shorten the entry
    smi_n <= 1'b0;
    wst(5'h01);
    smi_n    <= 1'b1;
    dly      <= 4'h5;
    stop_cmd <= 1'b1;
    wst(5'h04);
    chk(pbe_n, 1'b1);
    smi_n  <= 1'b0;
    lint   <= 2'h1;
    fsbirq <= 1'b1;
    repeat (4) @(posedge clk_i);
    {smi_n, lint, fsbirq} <= 4'h8;
    repeat (4) @(posedge clk_i);
    chk({pbe_n, state}, 6'h04);
    wb(4'hC, 1'b0, 32'h0);
    chk(q, 32'h29);
    wb(4'hC, 1'b1, 32'h3F);
    wb(4'hC, 1'b0, 32'h0);
    chk({q[5:0], pbe_n}, 7'h01);
    snoop <= 1'b1;
    wst(5'h08);
    snoop <= 1'b0;
    sdone <= 1'b1;
    @(posedge clk_i);
    sdone <= 1'b0;
    wst(5'h04);
    sleep_cmd <= 1'b1;
    wst(5'h10);
    sleep_cmd <= 1'b0;
    wst(5'h04);
    stop_cmd <= 1'b0;
    wst(5'h01);
    stop_cmd <= 1'b1;
    wst(5'h04);
    do_reset();
    chk(state, 5'h04);
    stop_cmd <= 1'b0;
    wst(5'h01);
    wb(4'h4, 1'b0, 32'h0);
    chk(q, 32'h01);
    wb(4'h0, 1'b1, 32'h2);
    wst(5'h02);
    lint <= 2'h2;
    wst(5'h01);
    lint <= 2'h0;
    wb(4'h0, 1'b1, 32'h1);
    smiret <= 1'b1;
    @(posedge clk_i);
    smiret <= 1'b0;
    wst(5'h02);
    {init_n, br0_n, addr_n} <= {2'h0, 25'h1FFFEE3};
    do_reset();
    chk({state, strap}, {5'h01, 10'h2BA});
    final_report();
  end
endmodule
